// [rstr_pkg.sv]
// rstr_pkg: shared constants for the rail sequencing, tracking and retry block
package rstr_pkg;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RAIL_ORDER   = 8'he0;
  localparam logic [7:0] CMD_VOLT_FOLLOW  = 8'he1;
  localparam logic [7:0] CMD_BCAST_GROUP  = 8'he2;
  localparam logic [7:0] CMD_IDENT_STRING = 8'he4;
  localparam logic [7:0] CMD_OC_RESPONSE  = 8'he5;

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int          ORD_PRE_EN   = 15;
  localparam int          ORD_PRE_LSB  = 8;
  localparam int          ORD_SEQ_EN   = 7;
  localparam int          ORD_SEQ_LSB  = 0;
  localparam logic [15:0] ORD_MASK     = 16'h9f9f;
  localparam logic [15:0] ORD_RESET    = 16'h0000;
  localparam int          TRK_EN       = 7;
  localparam int          TRK_HALF     = 2;
  localparam int          TRK_LIM_REF  = 1;
  localparam int          TRK_DOWN_OK  = 0;
  localparam logic [7:0]  TRK_MASK     = 8'h87;
  localparam int          GRP_SP_EN    = 21;
  localparam int          GRP_SP_LSB   = 16;
  localparam int          GRP_OP_EN    = 13;
  localparam int          GRP_OP_LSB   = 8;
  localparam int          GRP_PF_FAST  = 5;
  localparam int          GRP_PF_LSB   = 0;
  localparam logic [23:0] GRP_MASK     = 24'h3f3f3f;
  localparam logic [23:0] GRP_RESET    = 24'h000000;
  localparam logic [7:0]  OCR_RESET    = 8'h80;
  localparam logic [7:0]  OCR_FIXED    = 8'h80;
  localparam logic [7:0]  OCR_WR_MASK  = 8'h3f;
  localparam int          OCR_RTY_LSB  = 3;
  localparam int          OCR_DLY_LSB  = 0;
  localparam logic [2:0]  RETRY_NONE   = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER = 3'h7;
  localparam int          STAT_OC_BIT  = 7;
  localparam int          ID_LEN       = 16;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ         = 40000000;
  localparam longint RETRY_UNIT_MS  = 35;
  localparam longint RETRY_UNIT_CYC = (RETRY_UNIT_MS * CLK_HZ) / 1000;
  localparam int     RETRY_CNT_W    = 24;

  // ----------------------------------------------------------------
  // event bus types and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EVT_POWER_GOOD = 3'h1,
    EVT_POWER_DOWN = 3'h2,
    EVT_SETPOINT   = 3'h3,
    EVT_OPERATION  = 3'h4,
    EVT_POWER_FAIL = 3'h5
  } rstr_evt_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT_PRE,
    ST_ON,
    ST_RAMP_OFF,
    ST_FAULT_HOLD,
    ST_RETRY_WAIT
  } rstr_state_t;
endpackage

// [rstr_rom_if.sv]
// rstr_rom_if: read port between the control logic and the identifier store
`timescale 1ns/1ps
interface rstr_rom_if;
  logic       rd_en;
  logic [3:0] index;
  logic [7:0] data;

  modport ctrl (output rd_en, output index, input data);
  modport rom  (input rd_en, input index, output data);
endinterface

// [rstr_id_rom.sv]
// rstr_id_rom: fixed sixteen character identifier string, registered read
`timescale 1ns/1ps
module rstr_id_rom #(
  // arbitrary neutral identifier text
  parameter logic [127:0] ID_TEXT = "RAILSEQ-A0-FW01 "
) (
  input  wire logic I_CLK,
  input  wire logic I_RST,
  rstr_rom_if.rom   port
);
  logic [7:0] rom [rstr_pkg::ID_LEN];

  // first character sits in the top byte of the text, byte 0 of the block
  for (genvar g = 0; g < rstr_pkg::ID_LEN; g++) begin : g_chr
    assign rom[g] = ID_TEXT[8*(rstr_pkg::ID_LEN-1-g) +: 8];
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      port.data <= 8'h00;
    end else if (port.rd_en) begin
      port.data <= rom[port.index];
    end
  end
endmodule // rstr_id_rom

// [rstr_top.sv]
// rstr_top: rail sequencing, tracking options, group events and overcurrent retry
`timescale 1ns/1ps

// Summary of operation
// - with prequel on, output starts when enabled and prequel rail signalled power-good
// - with sequel on, output ramps off with delay after sequel rail signalled power-down
// - order setting: prequel enable 15, prequel id 12:8, sequel enable 7, id 4:0
// - order setting resets to zero; reserved bits read as zero
// - a written order setting overrides the strap derived one
// - only one channel may track; bit 7 enables tracking
// - ratio bit 2 selects full or half of the reference
// - limit bit 1 caps output at target or at the reference
// - bit 0 allows following the reference down before power good
// - setpoint events obeyed only when bit 21 set and group id 20:16 matches
// - operation events obeyed only when bit 13 set and group id 12:8 matches
// - matching power-fail: bit 5 set means instant off, else sequenced off
// - group setting defaults to ignoring setpoint and operation events; power-fail id 0 is obeyed; reserved bits read zero
// - sixteen character read-only identifier returned on block read; the code returns one character per read, chosen by i_RD_INDEX
// - overcurrent sets status flag and applies the programmed response
// - retry code 000 keeps output off until fault cleared; 001-110 unused
// - retry code 111 restarts endlessly until off command, bias loss or other fault
// - retry delay is (field plus one) times 35 ms
// - overcurrent response resets to 80h; bits 7:6 hold 10
module rstr_top #(
  parameter int RETRY_UNIT_CYC = int'(rstr_pkg::RETRY_UNIT_CYC)
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic        i_CMD_WR,
  input  wire logic        i_CMD_RD,
  input  wire logic [7:0]  i_CMD_CODE,
  input  wire logic [23:0] i_CMD_DATA,
  input  wire logic [3:0]  i_RD_INDEX,
  output logic      [23:0] o_RD_DATA,
  output logic             o_RD_VALID,
  output logic             o_RD_ERR,
  input  wire logic [15:0] i_STRAP_ORDER,
  input  wire logic [7:0]  i_STRAP_TRACK,
  input  wire logic        i_OTHER_TRACKING,
  input  wire logic [4:0]  i_RAIL_ID,
  input  wire logic        i_ENABLE,
  input  wire logic        i_BIAS_OK,
  input  wire logic        i_POWER_GOOD,
  input  wire logic        i_OC_FAULT,
  input  wire logic        i_OTHER_FAULT,
  input  wire logic        i_FAULT_CLEAR,
  input  wire logic [15:0] i_TOFF_DELAY,
  input  wire logic        i_EVT_VALID,
  input  wire logic [2:0]  i_EVT_TYPE,
  input  wire logic [4:0]  i_EVT_ID,
  input  wire logic [15:0] i_EVT_DATA,
  output logic             o_EVT_VALID,
  output logic      [2:0]  o_EVT_TYPE,
  output logic      [4:0]  o_EVT_ID,
  output logic             o_OUTPUT_EN,
  output logic      [7:0]  o_IOUT_STATUS,
  output logic             o_TRACK_EN,
  output logic             o_TRACK_HALF,
  output logic             o_TRACK_LIMIT_REF,
  output logic             o_TRACK_DOWN_OK,
  output logic      [15:0] o_VOUT_SETPOINT
);
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [15:0] order_reg;
  logic        order_written;
  logic [7:0]  track_reg;
  logic        track_init;
  logic [23:0] group_reg;
  logic [7:0]  ocr_reg;
  logic [15:0] order_eff;
  logic        wr_order;
  logic        wr_track;
  logic        wr_group;
  logic        wr_ocr;

  assign wr_order = i_CMD_WR && (i_CMD_CODE == rstr_pkg::CMD_RAIL_ORDER);
  assign wr_track = i_CMD_WR && (i_CMD_CODE == rstr_pkg::CMD_VOLT_FOLLOW);
  assign wr_group = i_CMD_WR && (i_CMD_CODE == rstr_pkg::CMD_BCAST_GROUP);
  assign wr_ocr   = i_CMD_WR && (i_CMD_CODE == rstr_pkg::CMD_OC_RESPONSE);

  // the strap only steers ordering until software writes the setting
  assign order_eff = order_written ? order_reg : (i_STRAP_ORDER & rstr_pkg::ORD_MASK);

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      order_reg     <= rstr_pkg::ORD_RESET;
      order_written <= 1'b0;
    end else if (wr_order) begin
      order_reg     <= i_CMD_DATA[15:0] & rstr_pkg::ORD_MASK;
      order_written <= 1'b1;
    end
  end

  // tracking setting loads from the strap on the first edge after reset
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      track_reg  <= 8'h00;
      track_init <= 1'b1;
    end else if (wr_track) begin
      track_reg  <= i_CMD_DATA[7:0] & rstr_pkg::TRK_MASK;
      track_reg[rstr_pkg::TRK_EN] <= i_CMD_DATA[rstr_pkg::TRK_EN] & ~i_OTHER_TRACKING;
      track_init <= 1'b0;
    end else if (track_init) begin
      track_reg  <= i_STRAP_TRACK & rstr_pkg::TRK_MASK;
      track_reg[rstr_pkg::TRK_EN] <= i_STRAP_TRACK[rstr_pkg::TRK_EN] & ~i_OTHER_TRACKING;
      track_init <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      group_reg <= rstr_pkg::GRP_RESET;
    end else if (wr_group) begin
      group_reg <= i_CMD_DATA & rstr_pkg::GRP_MASK;
    end
  end

  // top two bits are fixed at 10 whatever is written
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ocr_reg <= rstr_pkg::OCR_RESET;
    end else if (wr_ocr) begin
      ocr_reg <= rstr_pkg::OCR_FIXED | (i_CMD_DATA[7:0] & rstr_pkg::OCR_WR_MASK);
    end
  end

  // ----------------------------------------------------------------
  // tracking outputs
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      o_TRACK_EN        <= 1'b0;
      o_TRACK_HALF      <= 1'b0;
      o_TRACK_LIMIT_REF <= 1'b0;
      o_TRACK_DOWN_OK   <= 1'b0;
    end else begin
      o_TRACK_EN        <= track_reg[rstr_pkg::TRK_EN];
      o_TRACK_HALF      <= track_reg[rstr_pkg::TRK_HALF];
      o_TRACK_LIMIT_REF <= track_reg[rstr_pkg::TRK_LIM_REF];
      o_TRACK_DOWN_OK   <= track_reg[rstr_pkg::TRK_DOWN_OK] | i_POWER_GOOD;
    end
  end

  // ----------------------------------------------------------------
  // event bus decode
  // ----------------------------------------------------------------
  logic       pre_pg_evt;
  logic       pre_down_evt;
  logic       seq_down_evt;
  logic       sp_evt;
  logic       op_evt;
  logic       pf_evt;
  logic       pre_seen;
  logic       seq_down;
  logic       bcast_on;

  assign pre_pg_evt   = i_EVT_VALID && (i_EVT_TYPE == rstr_pkg::EVT_POWER_GOOD)
                        && (i_EVT_ID == order_eff[rstr_pkg::ORD_PRE_LSB +: 5]);
  assign pre_down_evt = i_EVT_VALID && (i_EVT_TYPE == rstr_pkg::EVT_POWER_DOWN)
                        && (i_EVT_ID == order_eff[rstr_pkg::ORD_PRE_LSB +: 5]);
  assign seq_down_evt = i_EVT_VALID && (i_EVT_TYPE == rstr_pkg::EVT_POWER_DOWN)
                        && (i_EVT_ID == order_eff[rstr_pkg::ORD_SEQ_LSB +: 5]);
  assign sp_evt = i_EVT_VALID && (i_EVT_TYPE == rstr_pkg::EVT_SETPOINT) && group_reg[rstr_pkg::GRP_SP_EN]
                  && (i_EVT_ID == group_reg[rstr_pkg::GRP_SP_LSB +: 5]);
  assign op_evt = i_EVT_VALID && (i_EVT_TYPE == rstr_pkg::EVT_OPERATION) && group_reg[rstr_pkg::GRP_OP_EN]
                  && (i_EVT_ID == group_reg[rstr_pkg::GRP_OP_LSB +: 5]);
  assign pf_evt = i_EVT_VALID && (i_EVT_TYPE == rstr_pkg::EVT_POWER_FAIL)
                  && (i_EVT_ID == group_reg[rstr_pkg::GRP_PF_LSB +: 5]);

  // prequel power-good is remembered until that rail reports power-down
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      pre_seen <= 1'b0;
    end else if (pre_pg_evt) begin
      pre_seen <= 1'b1;
    end else if (pre_down_evt) begin
      pre_seen <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      bcast_on        <= 1'b1;
      o_VOUT_SETPOINT <= 16'h0000;
    end else begin
      if (op_evt) begin
        bcast_on <= i_EVT_DATA[0];
      end
      if (sp_evt) begin
        o_VOUT_SETPOINT <= i_EVT_DATA;
      end
    end
  end

  // ----------------------------------------------------------------
  // output sequencer
  // ----------------------------------------------------------------
  rstr_pkg::rstr_state_t              state;
  rstr_pkg::rstr_state_t              next_state;
  logic [rstr_pkg::RETRY_CNT_W-1:0]   cnt;
  logic [rstr_pkg::RETRY_CNT_W-1:0]   next_cnt;
  logic [rstr_pkg::RETRY_CNT_W-1:0]   retry_load;
  logic [2:0]                         retry_code;
  logic                               run_req;
  logic                               pre_ok;
  logic                               oc_hit;

  assign retry_code = ocr_reg[rstr_pkg::OCR_RTY_LSB +: 3];
  assign retry_load = rstr_pkg::RETRY_CNT_W'((32'(ocr_reg[rstr_pkg::OCR_DLY_LSB +: 3]) + 32'd1)
                      * 32'(RETRY_UNIT_CYC));
  assign run_req    = i_ENABLE && bcast_on && i_BIAS_OK;
  assign pre_ok     = !order_eff[rstr_pkg::ORD_PRE_EN] || pre_seen;
  assign oc_hit     = i_OC_FAULT || i_OTHER_FAULT;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      rstr_pkg::ST_OFF: begin
        if (run_req) begin
          next_state = rstr_pkg::ST_WAIT_PRE;
        end
      end
      rstr_pkg::ST_WAIT_PRE: begin
        if (!run_req) begin
          next_state = rstr_pkg::ST_OFF;
        end else if (pre_ok) begin
          next_state = rstr_pkg::ST_ON;
        end
      end
      rstr_pkg::ST_ON, rstr_pkg::ST_RAMP_OFF: begin
        if (oc_hit) begin
          // 001-110 behave as no retry
          if (i_OC_FAULT && !i_OTHER_FAULT && retry_code == rstr_pkg::RETRY_FOREVER) begin
            next_state = rstr_pkg::ST_RETRY_WAIT;
            next_cnt   = retry_load;
          end else begin
            next_state = rstr_pkg::ST_FAULT_HOLD;
          end
        end else if (!i_BIAS_OK || (pf_evt && group_reg[rstr_pkg::GRP_PF_FAST])) begin
          next_state = rstr_pkg::ST_OFF;
        end else if (state == rstr_pkg::ST_ON) begin
          if (!run_req || pf_evt || (order_eff[rstr_pkg::ORD_SEQ_EN] && seq_down)) begin
            next_state = rstr_pkg::ST_RAMP_OFF;
            next_cnt   = rstr_pkg::RETRY_CNT_W'(i_TOFF_DELAY);
          end
        end else if (cnt == '0) begin
          next_state = rstr_pkg::ST_OFF;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      rstr_pkg::ST_FAULT_HOLD: begin
        if (i_FAULT_CLEAR) begin
          next_state = rstr_pkg::ST_OFF;
        end
      end
      rstr_pkg::ST_RETRY_WAIT: begin
        if (!run_req) begin
          next_state = rstr_pkg::ST_OFF;
        end else if (oc_hit) begin
          next_state = rstr_pkg::ST_FAULT_HOLD;
        end else if (cnt <= 1) begin
          next_state = rstr_pkg::ST_ON;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = rstr_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state <= rstr_pkg::ST_OFF;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // sequel power-down is latched in any state and cleared while in ST_OFF
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      seq_down <= 1'b0;
    end else if (seq_down_evt) begin
      seq_down <= 1'b1;
    end else if (state == rstr_pkg::ST_OFF) begin
      seq_down <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      o_OUTPUT_EN <= 1'b0;
    end else begin
      o_OUTPUT_EN <= (next_state == rstr_pkg::ST_ON) || (next_state == rstr_pkg::ST_RAMP_OFF);
    end
  end

  // ----------------------------------------------------------------
  // overcurrent status: set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      o_IOUT_STATUS <= 8'h00;
    end else if (i_OC_FAULT) begin
      o_IOUT_STATUS[rstr_pkg::STAT_OC_BIT] <= 1'b1;
    end else if (i_FAULT_CLEAR) begin
      o_IOUT_STATUS[rstr_pkg::STAT_OC_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outgoing events
  // ----------------------------------------------------------------
  logic pg_q;
  logic out_q;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      pg_q        <= 1'b0;
      out_q       <= 1'b0;
      o_EVT_VALID <= 1'b0;
      o_EVT_TYPE  <= 3'h0;
      o_EVT_ID    <= 5'h00;
    end else begin
      pg_q        <= i_POWER_GOOD && o_OUTPUT_EN;
      out_q       <= o_OUTPUT_EN;
      o_EVT_VALID <= 1'b0;
      o_EVT_ID    <= i_RAIL_ID;
      if (out_q && !o_OUTPUT_EN) begin
        o_EVT_VALID <= 1'b1;
        o_EVT_TYPE  <= rstr_pkg::EVT_POWER_DOWN;
      end else if (i_POWER_GOOD && o_OUTPUT_EN && !pg_q) begin
        o_EVT_VALID <= 1'b1;
        o_EVT_TYPE  <= rstr_pkg::EVT_POWER_GOOD;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port: two cycles for every code so the id store fits in
  // ----------------------------------------------------------------
  rstr_rom_if  rom_bus ();
  logic        rd_pend;
  logic        rd_is_id;
  logic        rd_bad;
  logic [23:0] rd_stage;

  assign rom_bus.rd_en = i_CMD_RD && (i_CMD_CODE == rstr_pkg::CMD_IDENT_STRING);
  assign rom_bus.index = i_RD_INDEX;

  rstr_id_rom u_id_rom (
    .I_CLK (I_CLK),
    .I_RST (I_RST),
    .port  (rom_bus.rom)
  );

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rd_pend  <= 1'b0;
      rd_is_id <= 1'b0;
      rd_bad   <= 1'b0;
      rd_stage <= 24'h000000;
    end else begin
      rd_pend  <= i_CMD_RD;
      rd_is_id <= rom_bus.rd_en;
      rd_bad   <= 1'b0;
      rd_stage <= 24'h000000;
      case (i_CMD_CODE)
        rstr_pkg::CMD_RAIL_ORDER:   rd_stage <= {8'h00, order_eff};
        rstr_pkg::CMD_VOLT_FOLLOW:  rd_stage <= {16'h0000, track_reg};
        rstr_pkg::CMD_BCAST_GROUP:  rd_stage <= group_reg;
        rstr_pkg::CMD_OC_RESPONSE:  rd_stage <= {16'h0000, ocr_reg};
        rstr_pkg::CMD_IDENT_STRING: rd_stage <= 24'h000000;
        default:                    rd_bad   <= i_CMD_RD;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      o_RD_VALID <= 1'b0;
      o_RD_ERR   <= 1'b0;
      o_RD_DATA  <= 24'h000000;
    end else begin
      o_RD_VALID <= rd_pend;
      o_RD_ERR   <= rd_bad;
      o_RD_DATA  <= rd_is_id ? {16'h0000, rom_bus.data} : rd_stage;
    end
  end
endmodule // rstr_top

// [rstr_checker.sv]
// rstr_checker: port level assertions for the rail sequencer
`timescale 1ns/1ps
module rstr_checker (
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        i_CMD_RD,
  input wire logic [7:0]  i_CMD_CODE,
  input wire logic [23:0] o_RD_DATA,
  input wire logic        o_RD_VALID,
  input wire logic [4:0]  i_RAIL_ID,
  input wire logic        i_ENABLE,
  input wire logic        i_BIAS_OK,
  input wire logic        i_OC_FAULT,
  input wire logic        i_OTHER_TRACKING,
  input wire logic        o_EVT_VALID,
  input wire logic [2:0]  o_EVT_TYPE,
  input wire logic [4:0]  o_EVT_ID,
  input wire logic        o_OUTPUT_EN,
  input wire logic [7:0]  o_IOUT_STATUS,
  input wire logic        o_TRACK_EN
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  property p_rd_lat; i_CMD_RD |-> ##2 o_RD_VALID; endproperty
  property p_ord_rsv; i_CMD_RD && i_CMD_CODE == 8'he0 |-> ##2 (o_RD_DATA & ~24'h009f9f) == 24'h0; endproperty
  property p_grp_rsv; i_CMD_RD && i_CMD_CODE == 8'he2 |-> ##2 (o_RD_DATA & 24'hc0c0c0) == 24'h0; endproperty
  property p_ocr_fix; i_CMD_RD && i_CMD_CODE == 8'he5 |-> ##2 o_RD_DATA[7:6] == 2'b10; endproperty
  property p_oc_flag; i_OC_FAULT |-> ##[1:2] o_IOUT_STATUS[7]; endproperty
  property p_oc_off; i_OC_FAULT && o_OUTPUT_EN |-> ##[1:3] !o_OUTPUT_EN; endproperty
  property p_bias_off; !i_BIAS_OK |-> ##[1:3] !o_OUTPUT_EN; endproperty
  property p_evt_id; o_EVT_VALID |-> o_EVT_ID == i_RAIL_ID; endproperty
  property p_pd_evt; $fell(o_OUTPUT_EN) |=> o_EVT_VALID && o_EVT_TYPE == rstr_pkg::EVT_POWER_DOWN; endproperty
  property p_start; $rose(o_OUTPUT_EN) |-> $past(i_ENABLE) && $past(i_BIAS_OK); endproperty
  property p_trk_one; i_OTHER_TRACKING [*3] |-> !o_TRACK_EN; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  a_ord_rsv: assert property (p_ord_rsv) else $error("order reserved bits set");
  a_grp_rsv: assert property (p_grp_rsv) else $error("group reserved bits set");
  a_ocr_fix: assert property (p_ocr_fix) else $error("response top bits wrong");
  a_oc_flag: assert property (p_oc_flag) else $error("overcurrent flag missing");
  a_oc_off: assert property (p_oc_off) else $error("output kept on after fault");
  a_bias_off: assert property (p_bias_off) else $error("output on without bias");
  a_evt_id: assert property (p_evt_id) else $error("event id wrong");
  a_pd_evt: assert property (p_pd_evt) else $error("power-down event missing");
  a_start: assert property (p_start) else $error("start without enable");
  a_trk_one: assert property (p_trk_one) else $error("both channels tracking");
  c_retry: cover property ($rose(o_OUTPUT_EN) && o_IOUT_STATUS[7]);
  c_pd: cover property (o_EVT_VALID && o_EVT_TYPE == rstr_pkg::EVT_POWER_DOWN);
  c_pg: cover property (o_EVT_VALID && o_EVT_TYPE == rstr_pkg::EVT_POWER_GOOD);
endmodule // rstr_checker

bind rstr_top rstr_checker rstr_checker_inst (.I_CLK(I_CLK), .I_RST(I_RST), .i_CMD_RD(i_CMD_RD),
  .i_CMD_CODE(i_CMD_CODE), .o_RD_DATA(o_RD_DATA), .o_RD_VALID(o_RD_VALID), .i_RAIL_ID(i_RAIL_ID),
  .i_ENABLE(i_ENABLE), .i_BIAS_OK(i_BIAS_OK), .i_OC_FAULT(i_OC_FAULT), .i_OTHER_TRACKING(i_OTHER_TRACKING),
  .o_EVT_VALID(o_EVT_VALID), .o_EVT_TYPE(o_EVT_TYPE), .o_EVT_ID(o_EVT_ID), .o_OUTPUT_EN(o_OUTPUT_EN),
  .o_IOUT_STATUS(o_IOUT_STATUS), .o_TRACK_EN(o_TRACK_EN));

// [rstr_peer_model.sv]
// rstr_peer_model: peer rails sending events on the inter-device event bus
`timescale 1ns/1ps
module rstr_peer_model (
  input  wire logic        I_CLK,
  input  wire logic        i_req,
  input  wire logic [2:0]  i_type,
  input  wire logic [4:0]  i_id,
  input  wire logic [15:0] i_data,
  output logic             o_valid,
  output logic      [2:0]  o_type,
  output logic      [4:0]  o_id,
  output logic      [15:0] o_data
);
  always_ff @(posedge I_CLK) begin
    o_valid <= i_req;
    if (i_req) begin
      o_type <= i_type;
      o_id   <= i_id;
      o_data <= i_data;
    end else begin
      // idle bus flips so a stale event can never look valid
      o_type <= ~o_type;
      o_id   <= ~o_id;
      o_data <= ~o_data;
    end
  end
endmodule // rstr_peer_model

// [rail_sequence_track_retry_tb.sv]
// rail_sequence_track_retry_tb: self-checking bench for rstr_top
`timescale 1ns/1ps
module rail_sequence_track_retry_tb;
  localparam int RU = 20;
  localparam logic [4:0] RAIL = 5'h0a;
  localparam logic [127:0] IDS = "RAILSEQ-A0-FW01 ";
  logic clk = 0, rst = 1, wr = 0, rd = 0, en = 0, bias = 1, pg = 0, oc = 0, fclr = 0, oth = 0, req = 0;
  logic [7:0] code = 0;
  logic [23:0] wd = 0;
  logic [3:0] idx = 0;
  logic [2:0] et = 0;
  logic [4:0] eid = 0;
  logic [15:0] ed = 0, toff = 16'h0005, strap = 16'h0000;
  logic rv, rerr, pv, ov, oen, tke, tkh, tkl, tkd;
  logic [23:0] rdat;
  logic [2:0] pt, ot;
  logic [4:0] pid, oid;
  logic [15:0] pd, vsp;
  logic [7:0] ios;
  int err_count = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  rstr_peer_model rstr_peer_model_inst (.I_CLK(clk), .i_req(req), .i_type(et), .i_id(eid), .i_data(ed),
    .o_valid(pv), .o_type(pt), .o_id(pid), .o_data(pd));
  rstr_top #(.RETRY_UNIT_CYC(RU)) rstr_top_inst (.I_CLK(clk), .I_RST(rst), .i_CMD_WR(wr), .i_CMD_RD(rd),
    .i_CMD_CODE(code), .i_CMD_DATA(wd), .i_RD_INDEX(idx), .o_RD_DATA(rdat), .o_RD_VALID(rv), .o_RD_ERR(rerr),
    .i_STRAP_ORDER(strap), .i_STRAP_TRACK(8'h00), .i_OTHER_TRACKING(oth), .i_RAIL_ID(RAIL), .i_ENABLE(en),
    .i_BIAS_OK(bias), .i_POWER_GOOD(pg), .i_OC_FAULT(oc), .i_OTHER_FAULT(1'b0), .i_FAULT_CLEAR(fclr),
    .i_TOFF_DELAY(toff), .i_EVT_VALID(pv), .i_EVT_TYPE(pt), .i_EVT_ID(pid), .i_EVT_DATA(pd), .o_EVT_VALID(ov),
    .o_EVT_TYPE(ot), .o_EVT_ID(oid), .o_OUTPUT_EN(oen), .o_IOUT_STATUS(ios), .o_TRACK_EN(tke),
    .o_TRACK_HALF(tkh), .o_TRACK_LIMIT_REF(tkl), .o_TRACK_DOWN_OK(tkd), .o_VOUT_SETPOINT(vsp));
  // ----------------
  // shared tasks
  // ----------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] c, input logic [23:0] d);
    @(negedge clk) {wr, code, wd} = {1'b1, c, d};
    @(negedge clk) wr = 0;
    @(negedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] c, input logic [3:0] i, output logic [23:0] q);
    @(negedge clk) {rd, code, idx} = {1'b1, c, i};
    @(negedge clk) rd = 0;
    @(negedge clk) q = rdat;
    chk(rv, 1);
  endtask
  task automatic ev(input logic [2:0] t, input logic [4:0] i, input logic [15:0] d);
    @(negedge clk) {req, et, eid, ed} = {1'b1, t, i, d};
    @(negedge clk) req = 0;
  endtask
  task automatic wait_out(input logic v, input int lim, output int n);
    n = 0;
    while (oen !== v && n < lim) begin
      @(negedge clk) n++;
    end
    chk(oen, v);
  endtask
  task automatic wait_evt(input logic [2:0] t);
    int n;
    n = 0;
    while (ov !== 1'b1 && n < 8) begin
      @(negedge clk) n++;
    end
    chk({ov, ot, oid}, {1'b1, t, RAIL});
  endtask
  task automatic oc_hit;
    int n;
    @(negedge clk) oc = 1;
    @(negedge clk) oc = 0;
    chk(ios[7], 1);
    wait_out(0, 4, n);
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_regs;
    logic [23:0] q;
    logic [7:0] tv [3] = '{8'hff, 8'h05, 8'h02};
    rd_reg(8'he0, 0, q);
    chk(q, 24'h0);
    rd_reg(8'he5, 0, q);
    chk(q, 24'h80);
    strap = 16'h8103;
    rd_reg(8'he0, 0, q);
    chk(q, 24'h8103);
    wr_reg(8'he0, 24'hffffff);
    rd_reg(8'he0, 0, q);
    chk(q, 24'h9f9f);
    wr_reg(8'he2, 24'hffffff);
    rd_reg(8'he2, 0, q);
    chk(q, 24'h3f3f3f);
    wr_reg(8'he5, 24'hff);
    rd_reg(8'he5, 0, q);
    chk(q, 24'hbf);
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'he1, tv[i]);
      chk({tke, tkh, tkl, tkd}, {tv[i][7], tv[i][2:0]});
    end
    oth = 1;
    wr_reg(8'he1, 24'h80);
    repeat (3) @(negedge clk);
    chk(tke, 0);
    oth = 0;
    wr_reg(8'he4, 24'h0);
    for (int i = 0; i < 16; i++) begin
      rd_reg(8'he4, i[3:0], q);
      chk(q, {16'h0, IDS[127-8*i -: 8]});
    end
    rd_reg(8'he3, 0, q);
    chk({rerr, q}, {1'b1, 24'h0});
    wr_reg(8'he2, 24'h0);
    wr_reg(8'he0, 24'h8387);
  endtask
  task automatic t_seq;
    int n;
    en = 1;
    ev(3'h1, 5'h04, 0);
    repeat (6) @(negedge clk);
    chk(oen, 0);
    ev(3'h1, 5'h03, 0);
    wait_out(1, 8, n);
    pg = 1;
    wait_evt(3'h1);
    ev(3'h2, 5'h07, 0);
    repeat (5) @(negedge clk);
    chk(oen, 1);
    wait_out(0, 8, n);
    en = 0;
    pg = 0;
    wait_evt(3'h2);
    wr_reg(8'he0, 24'h0);
  endtask
  task automatic t_grp;
    int n;
    wr_reg(8'he2, 24'h252922);
    en = 1;
    wait_out(1, 8, n);
    ev(3'h3, 5'h06, 16'h1234);
    repeat (3) @(negedge clk);
    chk(vsp, 0);
    ev(3'h3, 5'h05, 16'h1234);
    repeat (3) @(negedge clk);
    chk(vsp, 16'h1234);
    toff = 16'd40;
    ev(3'h4, 5'h08, 0);
    repeat (4) @(negedge clk);
    chk(oen, 1);
    ev(3'h4, 5'h09, 0);
    wait_out(0, 60, n);
    ev(3'h4, 5'h09, 1);
    wait_out(1, 8, n);
    ev(3'h5, 5'h02, 0);
    wait_out(0, 3, n);
    wait_out(1, 8, n);
    wr_reg(8'he2, 24'h252902);
    ev(3'h5, 5'h02, 0);
    repeat (8) @(negedge clk);
    chk(oen, 1);
    wait_out(0, 60, n);
    en = 0;
    toff = 16'd5;
  endtask
  task automatic t_retry;
    int n;
    wr_reg(8'he5, 24'h3a);
    en = 1;
    wait_out(1, 8, n);
    oc_hit();
    wait_out(1, 100, n);
    chk(n inside {[3*RU-3:3*RU+3]}, 1);
    wr_reg(8'he5, 24'h80);
    oc_hit();
    repeat (100) @(negedge clk);
    chk(oen, 0);
    @(negedge clk) fclr = 1;
    @(negedge clk) fclr = 0;
    wait_out(1, 10, n);
    wr_reg(8'he5, 24'h38);
    oc_hit();
    en = 0;
    repeat (40) @(negedge clk);
    chk(oen, 0);
    en = 1;
    wait_out(1, 8, n);
    bias = 0;
    wait_out(0, 3, n);
    bias = 1;
  endtask
  task automatic summarize;
    $display("err_count=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    t_regs();
    t_seq();
    t_grp();
    t_retry();
    summarize();
  end
  initial begin
    #100us;
    err_count++;
    summarize();
  end
endmodule // rail_sequence_track_retry_tb
